//--- hw/mbc_consts.svh
// constants for the branch selector and checkout logic
`ifndef MBC_CONSTS_SVH
`define MBC_CONSTS_SVH
`define MBC_ADDR_CTRL 8'h00
`define MBC_ADDR_STAT 8'h04
`define MBC_ADDR_SENSE12 8'h08
`define MBC_ADDR_SENSE23 8'h0C
`define MBC_ADDR_IC 8'h10
`define MBC_ADDR_DREG 8'h14
`define MBC_CTRL_HALT_MODE 0
`define MBC_CTRL_HIGH_BANK 1
`define MBC_SENSE12_CHECKOUT_BIT 4
`define MBC_SENSE12_MULTI_BIT 7
`define MBC_UNIT_HW 8'hAA
`define MBC_UNIT_STAT 8'h00
`define MBC_ALL_ONES 8'hFF
`define MBC_ZERO8 8'h00
`define MBC_ADD_B 8'h01
`define MBC_BANK_LO_PAT 8'h5A
`define MBC_BANK_HI_PAT 8'hA5
`define MBC_TRAP_ADDR 12'h000
`define MBC_ENTRY_ADDR 12'h010
`define MBC_IC_STEP 12'h001
`define MBC_LAST_BIT 3'h7
`define MBC_BIT_STEP 3'h1
`define MBC_LS_OPERAND 4'h0
`define MBC_LS_BANK_TEST 4'h5
`endif

//--- hw/mbc_pkg.sv
// types shared by the branch selector and checkout logic
package mbc_pkg;
    // one-hot checkout sequencer states
    typedef enum logic [12:0] {
        MBC_IDLE = 13'h0001,
        MBC_ENTRY = 13'h0002,
        MBC_DSET = 13'h0004,
        MBC_DCHK = 13'h0008,
        MBC_DCLR = 13'h0010,
        MBC_ADDER = 13'h0020,
        MBC_BANK_LO = 13'h0040,
        MBC_BANK_HI = 13'h0080,
        MBC_BANK_CHK = 13'h0100,
        MBC_BUS = 13'h0200,
        MBC_FLAGD = 13'h0400,
        MBC_ERR = 13'h0800,
        MBC_HALT = 13'h1000
    } mbc_state_e;
    // pin inputs that cross into the clk_sys domain
    typedef struct packed {
        logic [15:0] cond_n;     // branch condition lines, active low
        logic [7:0] bus_in;      // inbound tape unit bus, 1 = active
        logic busy_tach;         // busy or tachometer line, 1 = active
        logic ccs_switch;        // control check stop switch on
        logic [7:0] partner_xout; // first processor external out reg a
        logic trap_req;          // partner trap to address zero
    } mbc_pins_s;
    // local store write port
    typedef struct packed {
        logic we;
        logic high_bank;
        logic [3:0] addr;
        logic [7:0] data;
    } mbc_ls_wr_s;
endpackage

//--- hw/mbc_branch_sel.sv
// branch condition selector: code field to one active-low line
`include "mbc_consts.svh"
module mbc_branch_sel
    import mbc_pkg::*;
(
    input wire logic [0:7] micro_word, // microinstruction register
    input wire logic [15:0] cond_n,    // synced condition lines
    output logic taken,                // selected line asserted
    output logic code_valid,           // code field is a defined one
    output logic multi_active          // two or more lines asserted
);
    logic [15:0] act;  // lines as active high
    logic [3:0] index; // line number from the code field
    // decode bits 3..7; bit 4 must be one
    // index 0..7 for bit3=0: data end/ok, gain, flag a, flag b, parity env,
    // fwd/back, record start/transfer, gap
    // index 8..15 for bit3=1: 6250, trk1 env, flag c, flag d, env loss,
    // tape mark cfg, busy/tach, interrupt
    always_comb begin
        act = ~cond_n;
        index = {micro_word[3], micro_word[5], micro_word[6], micro_word[7]};
        code_valid = micro_word[4];
        // taken only on a low level of the selected line
        taken = code_valid & act[index];
        // more than one bit set when clearing the lowest leaves any
        multi_active = |(act & (act - 16'h0001));
    end
endmodule

//--- hw/mbc_local_store.sv
// local store: 32 registers of eight data bits plus parity
`include "mbc_consts.svh"
module mbc_local_store
    import mbc_pkg::*;
(
    input wire logic clk_sys,
    input mbc_ls_wr_s wr,           // write port
    input wire logic rd_high_bank,  // read from upper bank
    input wire logic [3:0] rd_addr, // register within bank
    output logic [7:0] rd_data,     // data bits
    output logic rd_par_ok          // stored parity is odd
);
    // 32 entries, numbered 0..31, data plus parity
    logic [8:0] mem [0:31];
    // no reset: contents are unknown after power on
    always_ff @(posedge clk_sys) begin
        if (wr.we) begin
            // bank bit selects upper half
            mem[{wr.high_bank, wr.addr}] <= {~^wr.data, wr.data};
        end
    end
    // asynchronous read of the addressed entry
    always_comb begin
        rd_data = mem[{rd_high_bank, rd_addr}][7:0];
        rd_par_ok = ^mem[{rd_high_bank, rd_addr}];
    end
endmodule

//--- hw/mbc_top.sv
// second processor branch selection and checkout error logic
// Overview of operation
// - code is microinstruction bits 3..7, bit4 set
// - codes 01000-01011 select first four lines
// - codes 01100-01111 select next four lines
// - codes 11000-11011 select density, track, flags
// - codes 11100-11111 select loss, mark, busy, interrupt
// - sense12 bit7 when several lines active
// - sense12 bit4 on checkout hardware fault
// - halt on error if halt mode and switch
// - sense23 holds unit code aa or 00
// - all-ones out byte plus trap starts checkout
// - error raised by hardware error transfer step
// - that step advances instruction counter by one
// - local store not cleared before checkout
// - each data bit sets, clears, branch follows
// - carry out with nonzero result is error
// - bank test step always writes upper local store; high bank control bit is only read back
// - finish by raising flag d; never on fails
// - active tape bus or busy line errors
// - 32 local store entries, eight bits plus parity
//
// Added by the designer: strobed register access and the register offsets.
`include "mbc_consts.svh"
module mbc_top
    import mbc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [0:7] micro_word,
    input mbc_pins_s pins,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic branch_taken,
    output logic status_flag_d,
    output logic halted,
    output logic hw_error,
    output logic [11:0] instr_counter
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    mbc_pins_s s1_reg, s2_reg, s3_reg;       // three stages per pin bit
    mbc_pins_s pin_q_reg, pin_q_next;        // accepted pin levels
    logic trap_d_reg;                        // previous accepted trap level
    // a change counts once the second and third stage agree
    genvar gi;
    generate
        for (gi = 0; gi < $bits(mbc_pins_s); gi = gi + 1) begin : g_sync
            always_comb begin
                pin_q_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : pin_q_reg[gi];
            end
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    s1_reg[gi] <= 1'b1;
                    s2_reg[gi] <= 1'b1;
                    s3_reg[gi] <= 1'b1;
                    pin_q_reg[gi] <= 1'b1;
                end else begin
                    s1_reg[gi] <= pins[gi];
                    s2_reg[gi] <= s1_reg[gi];
                    s3_reg[gi] <= s2_reg[gi];
                    pin_q_reg[gi] <= pin_q_next[gi];
                end
            end
        end
    endgenerate
    ////////////////////////////////////////////////////////////////////////
    // branch selection
    logic sel_taken;   // selected line asserted
    logic sel_valid;   // defined code
    logic sel_multi;   // several lines asserted
    mbc_branch_sel u_sel (
        .micro_word(micro_word),
        .cond_n(pin_q_reg.cond_n),
        .taken(sel_taken),
        .code_valid(sel_valid),
        .multi_active(sel_multi)
    );
    ////////////////////////////////////////////////////////////////////////
    // local store
    mbc_ls_wr_s ls_wr;      // write port from sequencer
    logic ls_rd_high;       // read bank
    logic [3:0] ls_rd_addr; // read entry
    logic [7:0] ls_rd_data; // read data
    logic ls_par_ok;        // read parity good
    mbc_local_store u_ls (
        .clk_sys(clk_sys),
        .wr(ls_wr),
        .rd_high_bank(ls_rd_high),
        .rd_addr(ls_rd_addr),
        .rd_data(ls_rd_data),
        .rd_par_ok(ls_par_ok)
    );
    ////////////////////////////////////////////////////////////////////////
    // checkout sequencer state
    mbc_state_e state_reg, state_next;       // sequencer state
    logic [11:0] ic_reg, ic_next;            // instruction counter
    logic [7:0] dreg_reg, dreg_next;         // data register under test
    logic [2:0] bit_reg, bit_next;           // data bit under test
    logic flagd_reg, flagd_next;             // status flag d toward partner
    logic halt_reg, halt_next;               // halted at trap
    logic err_reg, err_next;                 // hardware error latch
    logic [7:0] unit_reg, unit_next;         // replaceable unit code
    logic ext_reg, ext_next;                 // extended sense present
    logic [7:0] fail_unit;                   // unit code of current failure
    logic fail;                              // failure in this step
    logic start;                             // trap with all-ones byte
    logic [8:0] sum;                         // adder result with carry
    logic [7:0] bit_mask;                    // one-hot data bit
    logic halt_mode_reg, high_bank_reg;      // control bits
    logic [7:0] sense12_reg, sense12_next;   // sense byte 12
    // partner trap edge with all-ones byte starts checkout
    always_comb begin
        start = pin_q_reg.trap_req & ~trap_d_reg & (pin_q_reg.partner_xout == `MBC_ALL_ONES);
        bit_mask = 8'h01 << bit_reg;
        // carry test: stored all-ones plus one
        sum = {1'b0, ls_rd_data} + {1'b0, `MBC_ADD_B};
    end
    // next-state and step logic
    always_comb begin
        state_next = state_reg;
        ic_next = ic_reg;
        dreg_next = dreg_reg;
        bit_next = bit_reg;
        flagd_next = flagd_reg;
        halt_next = halt_reg;
        err_next = err_reg;
        unit_next = unit_reg;
        ext_next = ext_reg;
        fail = 1'b0;
        fail_unit = `MBC_UNIT_HW;
        ls_wr = '0;
        ls_rd_high = 1'b0;
        ls_rd_addr = `MBC_LS_OPERAND;
        case (state_reg)
            MBC_IDLE: begin
                // wait for trap from partner
            end
            MBC_ENTRY: begin
                // unconditional branch from trap address to entry
                // operand written before any read
                ls_wr.we = 1'b1;
                ls_wr.addr = `MBC_LS_OPERAND;
                ls_wr.data = `MBC_ALL_ONES;
                ic_next = `MBC_ENTRY_ADDR;
                dreg_next = `MBC_ZERO8;
                bit_next = '0;
                state_next = MBC_DSET;
            end
            MBC_DSET: begin
                // set the bit under test
                dreg_next = dreg_reg | bit_mask;
                state_next = MBC_DCHK;
            end
            MBC_DCHK: begin
                // bit must read one, then clear it
                if (!(|(dreg_reg & bit_mask))) begin
                    fail = 1'b1;
                end
                dreg_next = dreg_reg & ~bit_mask;
                state_next = MBC_DCLR;
            end
            MBC_DCLR: begin
                // bit must read zero
                if (|(dreg_reg & bit_mask)) begin
                    fail = 1'b1;
                end else if (bit_reg == `MBC_LAST_BIT) begin
                    state_next = MBC_ADDER;
                end else begin
                    bit_next = bit_reg + `MBC_BIT_STEP;
                    state_next = MBC_DSET;
                end
            end
            MBC_ADDER: begin
                // carry must come with an all-zero result
                if (!sum[8] || (sum[7:0] != `MBC_ZERO8) || !ls_par_ok) begin
                    fail = 1'b1;
                end
                state_next = MBC_BANK_LO;
            end
            MBC_BANK_LO: begin
                // low bank pattern
                ls_wr.we = 1'b1;
                ls_wr.addr = `MBC_LS_BANK_TEST;
                ls_wr.data = `MBC_BANK_LO_PAT;
                state_next = MBC_BANK_HI;
            end
            MBC_BANK_HI: begin
                // same opcode in high mode lands in upper bank
                ls_wr.we = 1'b1;
                ls_wr.high_bank = 1'b1;
                ls_wr.addr = `MBC_LS_BANK_TEST;
                ls_wr.data = `MBC_BANK_HI_PAT;
                ls_rd_addr = `MBC_LS_BANK_TEST;
                if (ls_rd_data != `MBC_BANK_LO_PAT) begin
                    fail = 1'b1;
                end
                state_next = MBC_BANK_CHK;
            end
            MBC_BANK_CHK: begin
                // upper bank must hold its own pattern; low one was checked in the step before
                ls_rd_high = 1'b1;
                ls_rd_addr = `MBC_LS_BANK_TEST;
                if (ls_rd_data != `MBC_BANK_HI_PAT) begin
                    fail = 1'b1;
                end
                state_next = MBC_BUS;
            end
            MBC_BUS: begin
                // idle tape bus and busy line must be quiet
                if ((|pin_q_reg.bus_in) || pin_q_reg.busy_tach) begin
                    fail = 1'b1;
                end
                flagd_next = !fail; // no finish flag after a failed step
                state_next = MBC_FLAGD;
            end
            MBC_FLAGD: begin
                // finish by flag d; missing flag is a failure
                if (!flagd_reg) begin
                    fail = 1'b1;
                    fail_unit = `MBC_UNIT_STAT;
                end else begin
                    state_next = MBC_IDLE;
                end
            end
            MBC_ERR: begin
                // hardware error transfer step: counter plus one
                ic_next = ic_reg + `MBC_IC_STEP;
                err_next = 1'b1;
                // stop at trap only in halt mode with switch on
                if (halt_mode_reg && pin_q_reg.ccs_switch) begin
                    halt_next = 1'b1;
                    state_next = MBC_HALT;
                end else begin
                    state_next = MBC_IDLE;
                end
            end
            MBC_HALT: begin
                // held until a new trap
            end
            default: begin
                state_next = MBC_IDLE;
            end
        endcase
        // each passing checkout step advances the counter
        if (!(state_reg inside {MBC_IDLE, MBC_ENTRY, MBC_ERR, MBC_HALT})) begin
            ic_next = ic_reg + `MBC_IC_STEP;
        end
        // failing point executes the error transfer
        if (fail) begin
            ic_next = ic_reg;
            state_next = MBC_ERR;
            // unit code with extended sense
            unit_next = fail_unit;
            ext_next = 1'b1;
        end
        if (start) begin
            // trap to address zero restarts checkout
            state_next = MBC_ENTRY;
            ic_next = `MBC_TRAP_ADDR;
            flagd_next = 1'b0;
            halt_next = 1'b0;
            err_next = 1'b0;
        end
    end
    // sequencer registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg <= MBC_IDLE;
            ic_reg <= `MBC_TRAP_ADDR;
            dreg_reg <= `MBC_ZERO8;
            bit_reg <= '0;
            flagd_reg <= 1'b0;
            halt_reg <= 1'b0;
            err_reg <= 1'b0;
            unit_reg <= `MBC_UNIT_STAT;
            ext_reg <= 1'b0;
            trap_d_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            ic_reg <= ic_next;
            dreg_reg <= dreg_next;
            bit_reg <= bit_next;
            flagd_reg <= flagd_next;
            halt_reg <= halt_next;
            err_reg <= err_next;
            unit_reg <= unit_next;
            ext_reg <= ext_next;
            trap_d_reg <= pin_q_reg.trap_req;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // register port
    logic halt_mode_next, high_bank_next;  // control bits next
    logic [31:0] rdata_reg, rdata_next;    // read data one cycle later
    logic taken_reg;                       // registered branch result
    // control write, sense write-one-to-clear, set wins over clear
    always_comb begin
        halt_mode_next = halt_mode_reg;
        high_bank_next = high_bank_reg;
        sense12_next = sense12_reg;
        if (reg_wr && (reg_addr == `MBC_ADDR_CTRL)) begin
            halt_mode_next = reg_wdata[`MBC_CTRL_HALT_MODE];
            high_bank_next = reg_wdata[`MBC_CTRL_HIGH_BANK];
        end
        if (reg_wr && (reg_addr == `MBC_ADDR_SENSE12)) begin
            sense12_next = sense12_reg & ~reg_wdata[7:0];
        end
        // several branch lines at once
        if (sel_multi) begin
            sense12_next[`MBC_SENSE12_MULTI_BIT] = 1'b1;
        end
        // checkout hardware fault
        if (fail) begin
            sense12_next[`MBC_SENSE12_CHECKOUT_BIT] = 1'b1;
        end
    end
    // read mux; unmapped reads return zero
    always_comb begin
        rdata_next = '0;
        if (reg_rd) begin
            case (reg_addr)
                `MBC_ADDR_CTRL: rdata_next = {30'h0, high_bank_reg, halt_mode_reg};
                `MBC_ADDR_STAT: rdata_next = {26'h0, sel_valid, ext_reg, flagd_reg, err_reg, halt_reg,
                    state_reg == MBC_IDLE};
                `MBC_ADDR_SENSE12: rdata_next = {24'h0, sense12_reg};
                // sense23 valid only with extended sense
                `MBC_ADDR_SENSE23: rdata_next = {24'h0, ext_reg ? unit_reg : `MBC_ZERO8};
                `MBC_ADDR_IC: rdata_next = {20'h0, ic_reg};
                `MBC_ADDR_DREG: rdata_next = {24'h0, dreg_reg};
                default: rdata_next = '0;
            endcase
        end
    end
    // register port flops
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            halt_mode_reg <= 1'b0;
            high_bank_reg <= 1'b0;
            sense12_reg <= `MBC_ZERO8;
            rdata_reg <= '0;
            taken_reg <= 1'b0;
        end else begin
            halt_mode_reg <= halt_mode_next;
            high_bank_reg <= high_bank_next;
            sense12_reg <= sense12_next;
            rdata_reg <= rdata_next;
            // branch outcome for the current code
            taken_reg <= sel_taken;
        end
    end
    // outputs straight from flops
    always_comb begin
        reg_rdata = rdata_reg;
        branch_taken = taken_reg;
        status_flag_d = flagd_reg;
        halted = halt_reg;
        hw_error = err_reg;
        instr_counter = ic_reg;
    end
endmodule

//--- testbench/mbc_top_chk.sv
// assertion checker for the branch selector and checkout block
`include "mbc_consts.svh"
module mbc_top_chk
    import mbc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [0:7] micro_word,
    input mbc_pins_s pins,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic branch_taken,
    input wire logic status_flag_d,
    input wire logic halted,
    input wire logic hw_error,
    input wire logic [11:0] instr_counter
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////
    logic [2:0] calm_reg; // cycles the lines stayed unchanged
    logic [2:0] calm_next;
    logic [15:0] prev_reg; // lines one cycle ago
    logic sel_line; // line picked by the code field
    logic multi_low; // two or more lines asserted
    assign sel_line = pins.cond_n[{micro_word[3], micro_word[5], micro_word[6], micro_word[7]}];
    assign multi_low = $countones(~pins.cond_n) > 1;
    // settle counter, saturates at seven
    always_comb begin
        calm_next = calm_reg;
        if (pins.cond_n != prev_reg) begin
            calm_next = 3'h0;
        end else if (calm_reg != 3'h7) begin
            calm_next = calm_reg + 3'h1;
        end
    end
    // register the counter and the last lines
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            calm_reg <= 3'h0;
        end else begin
            calm_reg <= calm_next;
        end
        prev_reg <= pins.cond_n;
    end
    ////////////////////////////////////////////////////////////////
    property p_pick;
        calm_next >= 3'h6 && micro_word[4] |=> branch_taken == !$past(sel_line);
    endproperty
    a_pick: assert property (p_pick) else $error("branch does not follow selected line");
    property p_nocode;
        !micro_word[4] |=> !branch_taken;
    endproperty
    a_nocode: assert property (p_nocode) else $error("branch on undefined code");
    property p_multi;
        calm_next >= 3'h6 && multi_low && reg_rd && reg_addr == `MBC_ADDR_SENSE12 |=> reg_rdata[7];
    endproperty
    a_multi: assert property (p_multi) else $error("multi line bit not set");
    property p_unit;
        $past(reg_rd) && $past(reg_addr) == `MBC_ADDR_SENSE23 |-> reg_rdata[7:0] inside {8'hAA, 8'h00};
    endproperty
    a_unit: assert property (p_unit) else $error("bad unit code");
    property p_fault;
        hw_error && reg_rd && reg_addr == `MBC_ADDR_SENSE12 |=> reg_rdata[4];
    endproperty
    a_fault: assert property (p_fault) else $error("checkout fault bit missing");
    property p_step;
        $rose(hw_error) |-> instr_counter == $past(instr_counter) + 12'h001;
    endproperty
    a_step: assert property (p_step) else $error("counter step on error wrong");
    property p_halt;
        halted |-> hw_error;
    endproperty
    a_halt: assert property (p_halt) else $error("halt without error");
    property p_done;
        status_flag_d |-> !hw_error;
    endproperty
    a_done: assert property (p_done) else $error("finish flag with error");
endmodule
bind mbc_top mbc_top_chk u_chk (.clk_sys(clk_sys), .srst(srst), .micro_word(micro_word), .pins(pins),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .branch_taken(branch_taken),
    .status_flag_d(status_flag_d), .halted(halted), .hw_error(hw_error), .instr_counter(instr_counter));

//--- testbench/mbc_partner.sv
// model of the first processor starting a checkout
module mbc_partner (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic start, // begin one request
    input wire logic byte_ok, // load all ones, else a short byte
    output logic [7:0] xout, // external out register a
    output logic trap // trap to address zero
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] step_reg; // cycles into the request
    // byte first, trap raised once the byte has settled
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            step_reg <= 4'h0;
            xout <= 8'h00;
            trap <= 1'b0;
        end else if (start) begin
            step_reg <= 4'h1;
            xout <= byte_ok ? 8'hFF : 8'hFE;
        end else if (step_reg != 4'h0) begin
            step_reg <= step_reg + 4'h1;
            trap <= step_reg >= 4'h6 && step_reg < 4'hE;
        end
    end
endmodule

//--- testbench/mbc_top_tb.sv
// self-checking bench for the branch selector and checkout block
`include "mbc_consts.svh"
`define CHK(what, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            num_errors++; \
            $display("[ERR] %s exp %h got %h", what, exp, got); \
        end \
    end
module mbc_top_tb
    import mbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic [0:7] micro_word = 8'h00;
    logic [15:0] cond_n = 16'hFFFF; // all lines idle
    logic [7:0] bus_in = 8'h00;
    logic busy_tach = 1'b0;
    logic ccs_sw = 1'b0;
    logic go = 1'b0; // partner request pulse
    logic byte_ok = 1'b1;
    logic [7:0] xout;
    logic trap;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic branch_taken, status_flag_d, halted, hw_error;
    logic [11:0] instr_counter;
    mbc_pins_s pins;
    int num_errors = 0;
    int num_checks = 0;
    assign pins = {cond_n, bus_in, busy_tach, ccs_sw, xout, trap};
    always #2.5 clk_sys = ~clk_sys;
    mbc_top DUT (.clk_sys(clk_sys), .srst(srst), .micro_word(micro_word), .pins(pins), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .branch_taken(branch_taken), .status_flag_d(status_flag_d), .halted(halted), .hw_error(hw_error),
        .instr_counter(instr_counter));
    mbc_partner u_partner (.clk_sys(clk_sys), .srst(srst), .start(go), .byte_ok(byte_ok), .xout(xout), .trap(trap));
    ////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // pass edges, then settle past the edge
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic start(input logic ok);
        @(posedge clk_sys);
        byte_ok <= ok;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
    endtask
    // bounded wait on hw_error (0) or finish flag (1)
    task automatic wait_for(input int which);
        int n;
        n = 0;
        while (((which == 0) ? hw_error : status_flag_d) !== 1'b1 && n < 300) begin
            ticks(1);
            n++;
        end
        if (n >= 300) begin
            num_errors++;
            give_verdict();
        end
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic test_branch();
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            micro_word <= {3'b000, i[3], 1'b1, i[2:0]};
            cond_n <= ~(16'h1 << i);
            ticks(7);
            `CHK("taken", 1'b1, branch_taken)
            @(posedge clk_sys);
            cond_n <= ~(16'h1 << ((i + 1) % 16));
            ticks(7);
            `CHK("not taken", 1'b0, branch_taken)
        end
        @(posedge clk_sys);
        micro_word <= 8'h00;
        cond_n <= 16'hFFFE;
        ticks(7);
        `CHK("undefined code", 1'b0, branch_taken)
        $display("test branch done");
    endtask
    task automatic test_regs();
        logic [31:0] d;
        @(posedge clk_sys);
        cond_n <= 16'hFFFC;
        ticks(7);
        reg_read(`MBC_ADDR_SENSE12, d);
        `CHK("multi set", 1'b1, d[7])
        @(posedge clk_sys);
        cond_n <= 16'hFFFF;
        ticks(7);
        reg_write(`MBC_ADDR_SENSE12, 32'h80);
        reg_read(`MBC_ADDR_SENSE12, d);
        `CHK("multi clear", 1'b0, d[7])
        reg_write(`MBC_ADDR_CTRL, 32'h3);
        reg_read(`MBC_ADDR_CTRL, d);
        `CHK("ctrl", 32'h3, d)
        reg_read(8'h40, d);
        `CHK("unmapped", 32'h0, d)
        $display("test regs done");
    endtask
    task automatic test_pass();
        start(1'b0);
        ticks(60);
        `CHK("refused start", 1'b0, status_flag_d)
        start(1'b1);
        wait_for(1);
        `CHK("pass error", 1'b0, hw_error)
        `CHK("pass halt", 1'b0, halted)
        $display("test pass done");
    endtask
    task automatic test_fail();
        logic [31:0] d;
        reg_write(`MBC_ADDR_CTRL, 32'h1);
        @(posedge clk_sys);
        bus_in <= 8'h01;
        ccs_sw <= 1'b1;
        start(1'b1);
        ticks(20);
        wait_for(0);
        ticks(3);
        `CHK("halt on", 1'b1, halted)
        `CHK("flag after fail", 1'b0, status_flag_d)
        reg_read(`MBC_ADDR_SENSE12, d);
        `CHK("fault bit", 1'b1, d[4])
        reg_read(`MBC_ADDR_SENSE23, d);
        `CHK("unit code", 8'hAA, d[7:0])
        @(posedge clk_sys);
        bus_in <= 8'h00;
        busy_tach <= 1'b1;
        ccs_sw <= 1'b0;
        start(1'b1);
        ticks(20);
        wait_for(0);
        ticks(3);
        `CHK("no halt", 1'b0, halted)
        `CHK("busy fault", 1'b0, status_flag_d)
        $display("test fail done");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        ticks(2);
        test_branch();
        test_regs();
        test_pass();
        test_fail();
        give_verdict();
    end
endmodule
